/* core/ldm_top.sv */
/*
 Clock and data recovery control for one quadrant: line decoding,
 violation and signature detection, loss of signal, event flags and
 interrupt. Assumes dual-rail line pins and a line clock pin arriving
 asynchronously, and a strobed register port on clk_sys.
*/
// What this block does
// - Line code bit at 1 decodes plain AMI with no substitution removal.
// - E1 with code bit 0 replaces each HDB3 signature with four zeros.
// - T1 with code bit 0 replaces each B8ZS signature with eight zeros.
// - E1 HDB3, rule bit 0: violation outside signature or same-polarity signature.
// - E1 HDB3, rule bit 1: violation when polarity equals previous violation.
// - Violation rule bit is ignored in T1 mode.
// - Algorithm bit picks high or low frequency jitter tolerance loop.
// - Threshold field sets 10/15, 31, 63 or 175 zero periods.
// - Loss status sets on the zero following the threshold count.
// - Loss status clears on any single mark.
// - Four enable bits let each event drive the interrupt.
// - Event flags set on detection, clear when status register is read.
// - Loss change flag sets on every loss status toggle.
// - N-zeros event after four zeros in E1 or eight in T1.
// - Signature event on B8ZS pattern in T1, two zeros then violation in E1.
`timescale 1ns/1ns
`default_nettype none
module ldm_top
   import ldm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic e1_mode,
   input wire logic rx_pos,
   input wire logic rx_neg,
   input wire logic rx_line_clk,
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [DATA_W-1:0] cpu_wdata,
   output logic [DATA_W-1:0] cpu_rdata,
   output logic rx_data,
   output logic rx_data_valid,
   output logic loss_of_signal_status,
   output logic recovery_algorithm_select,
   output logic interrupt_out_n
);
   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_pipe_reg;
   logic rst_n;
   logic [2:0] pos_sync_reg, neg_sync_reg, clk_sync_reg;
   logic pos_filt_reg, pos_filt_next, neg_filt_reg, neg_filt_next;
   logic clk_filt_reg, clk_filt_next;
   logic bit_en_reg, bit_en_next;
   logic [1:0] sym_reg, sym_next;

   // Two-stage reset release
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         rst_pipe_reg <= 2'h0;
      else
         rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
   end
   assign rst_n = rst_pipe_reg[1];

   // Accept a pin change once second and third stages agree
   always_comb
   begin
      pos_filt_next = (pos_sync_reg[1] == pos_sync_reg[2]) ? pos_sync_reg[2] : pos_filt_reg;
      neg_filt_next = (neg_sync_reg[1] == neg_sync_reg[2]) ? neg_sync_reg[2] : neg_filt_reg;
      clk_filt_next = (clk_sync_reg[1] == clk_sync_reg[2]) ? clk_sync_reg[2] : clk_filt_reg;
      bit_en_next = clk_filt_next && !clk_filt_reg;
      sym_next = bit_en_next ? {pos_filt_next, neg_filt_next && !pos_filt_next} : sym_reg;
   end

   // Register synchronisers and line symbol
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pos_sync_reg <= 3'h0;
         neg_sync_reg <= 3'h0;
         clk_sync_reg <= 3'h0;
         pos_filt_reg <= 1'b0;
         neg_filt_reg <= 1'b0;
         clk_filt_reg <= 1'b0;
         bit_en_reg <= 1'b0;
         sym_reg <= SYM_ZERO;
      end
      else
      begin
         pos_sync_reg <= {pos_sync_reg[1:0], rx_pos};
         neg_sync_reg <= {neg_sync_reg[1:0], rx_neg};
         clk_sync_reg <= {clk_sync_reg[1:0], rx_line_clk};
         pos_filt_reg <= pos_filt_next;
         neg_filt_reg <= neg_filt_next;
         clk_filt_reg <= clk_filt_next;
         bit_en_reg <= bit_en_next;
         sym_reg <= sym_next;
      end
   end

   // ------------------------------------------------------------
   // Registers and event flags
   // ------------------------------------------------------------
   logic [7:0] cfg_reg, cfg_next, ien_reg, ien_next;
   logic [7:4] flag_reg, flag_next;
   logic [7:0] rdata_next;
   logic irq_n_next, los_prev_reg;
   logic dec_bit, dec_valid, lcv_pulse, sig_pulse, los_stat, zrun_pulse;
   logic [7:4] ev;
   logic stat_rd;

   assign stat_rd = cpu_rd && (cpu_addr == ADDR_STAT);
   assign ev[EV_LCV] = lcv_pulse;
   assign ev[EV_LOS] = los_stat != los_prev_reg;
   assign ev[EV_SIG] = sig_pulse;
   assign ev[EV_ZRUN] = zrun_pulse;

   // Register writes, read data, flag update and interrupt
   always_comb
   begin
      cfg_next = cfg_reg;
      ien_next = ien_reg;
      if (cpu_wr && cpu_addr == ADDR_CFG)
         cfg_next = cpu_wdata;
      if (cpu_wr && cpu_addr == ADDR_IEN)
         ien_next = cpu_wdata & IEN_MASK;
      // Set wins over the read clear
      flag_next = (stat_rd ? 4'h0 : flag_reg) | ev;
      rdata_next = cpu_rdata;
      if (cpu_rd)
      begin
         case (cpu_addr)
            ADDR_CFG: rdata_next = cfg_reg;
            ADDR_IEN: rdata_next = ien_reg;
            ADDR_STAT: rdata_next = {flag_reg, 3'h0, los_stat};
            default: rdata_next = RD_UNMAPPED;
         endcase
      end
      irq_n_next = !(|(flag_next & ien_next[7:4]));
   end

   // Register state
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_reg <= CFG_RESET;
         ien_reg <= IEN_RESET;
         flag_reg <= 4'h0;
         los_prev_reg <= 1'b0;
         cpu_rdata <= RD_UNMAPPED;
         interrupt_out_n <= 1'b1;
         rx_data <= 1'b0;
         rx_data_valid <= 1'b0;
         loss_of_signal_status <= 1'b0;
         recovery_algorithm_select <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         ien_reg <= ien_next;
         flag_reg <= flag_next;
         los_prev_reg <= los_stat;
         cpu_rdata <= rdata_next;
         interrupt_out_n <= irq_n_next;
         rx_data <= dec_bit;
         rx_data_valid <= dec_valid;
         loss_of_signal_status <= los_stat;
         recovery_algorithm_select <= cfg_reg[CFG_ALG];
      end
   end

   // ------------------------------------------------------------
   // Decoder and loss monitor
   // ------------------------------------------------------------
   ldm_line_decoder u_dec (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bit_en(bit_en_reg),
      .sym_in(sym_reg),
      .e1_mode(e1_mode),
      .ami(cfg_reg[CFG_AMI]),
      .violation_rule_select(cfg_reg[CFG_VIOLATION_RULE_SELECT]),
      .data_bit(dec_bit),
      .data_valid(dec_valid),
      .lcv_pulse(lcv_pulse),
      .sig_pulse(sig_pulse)
   );

   ldm_loss_monitor u_los (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bit_en(bit_en_reg),
      .mark(sym_reg != SYM_ZERO),
      .e1_mode(e1_mode),
      .ami(cfg_reg[CFG_AMI]),
      .thr_sel(cfg_reg[CFG_THR_HI:CFG_THR_LO]),
      .los_status(los_stat),
      .zero_run_pulse(zrun_pulse)
   );

   // ------------------------------------------------------------
   // Assertions and cover points
   // ------------------------------------------------------------
   a_irq_follows_flags: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      interrupt_out_n == !(|(flag_reg & ien_reg[7:4])))
      else $error("interrupt output does not match enabled flags");

   a_flag_read_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      stat_rd && ev == 4'h0 |=> flag_reg == 4'h0)
      else $error("flags not cleared by status read");

   a_flag_set_wins: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ev[EV_LCV] |=> flag_reg[EV_LCV])
      else $error("violation event lost");

   a_loss_toggle_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $changed(los_stat) |=> flag_reg[EV_LOS])
      else $error("loss change not flagged");

   a_los_mark_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      bit_en_reg && sym_reg != SYM_ZERO |=> !los_stat)
      else $error("loss status not cleared by mark");

   a_los_only_zeros: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(los_stat) |-> $past(bit_en_reg) && $past(sym_reg) == SYM_ZERO)
      else $error("loss status rose without a zero");

   a_lcv_needs_mark: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      lcv_pulse |-> $past(bit_en_reg) && $past(sym_reg) != SYM_ZERO)
      else $error("violation without a mark");

   a_ien_low_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ien_reg[3:0] == 4'h0)
      else $error("unused enable bits set");

   a_alg_out: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cpu_wr && cpu_addr == ADDR_CFG ##2 1'b1
      |-> recovery_algorithm_select == $past(cpu_wdata[CFG_ALG], 2))
      else $error("algorithm select output wrong");

   // ------------------------------------------------------------
   // Register copies, flag hold and one-cycle pulses
   // ------------------------------------------------------------
   a_cfg_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cpu_wr && cpu_addr == ADDR_CFG |=> cfg_reg == $past(cpu_wdata))
      else $error("configuration write not stored");

   a_ien_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      cpu_wr && cpu_addr == ADDR_IEN |=> ien_reg[7:4] == $past(cpu_wdata[7:4]))
      else $error("enable write not stored");

   a_stat_read_data: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      stat_rd |=> cpu_rdata == {$past(flag_reg), 3'h0, $past(los_stat)})
      else $error("status read data wrong");

   a_flag_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      flag_reg[EV_SIG] && !stat_rd |=> flag_reg[EV_SIG])
      else $error("signature flag lost before read");

   a_zrun_single: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      zrun_pulse |=> !zrun_pulse)
      else $error("zero run event longer than one cycle");

   a_sig_single: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      sig_pulse |=> !sig_pulse)
      else $error("signature event longer than one cycle");

   a_valid_single: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      rx_data_valid |=> !rx_data_valid)
      else $error("decoded bit valid longer than one cycle");

   a_los_out_copy: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      loss_of_signal_status == $past(los_stat))
      else $error("loss status output does not follow monitor");

   // Main scenarios
   c_los_set: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(los_stat));
   c_zrun_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) zrun_pulse);
   c_lcv_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) lcv_pulse);
   c_sig_seen: cover property (@(posedge clk_sys) disable iff (!rst_n) sig_pulse);
   c_irq_low: cover property (@(posedge clk_sys) disable iff (!rst_n) !interrupt_out_n);
endmodule : ldm_top
`default_nettype wire

/* pkg/ldm_pkg.sv */
/*
 Constants shared by the line decoder and loss-of-signal monitor block:
 register offsets, bit positions, reset values, thresholds, symbol codes.
 Assumes an 8-bit microprocessor data bus and a quadrant-local address.
*/
package ldm_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_CFG = 8'h10;
   localparam logic [7:0] ADDR_IEN = 8'h11;
   localparam logic [7:0] ADDR_STAT = 8'h12;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] IEN_RESET = 8'h00;
   localparam logic [7:0] IEN_MASK = 8'hf0;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CFG_AMI = 7;
   localparam int CFG_THR_HI = 6;
   localparam int CFG_THR_LO = 5;
   localparam int CFG_ALG = 2;
   localparam int CFG_VIOLATION_RULE_SELECT = 1;
   localparam int EV_LCV = 7;
   localparam int EV_LOS = 6;
   localparam int EV_SIG = 5;
   localparam int EV_ZRUN = 4;
   localparam int STAT_LOS = 0;

   // ------------------------------------------------------------
   // Line symbols and counts
   // ------------------------------------------------------------
   typedef logic [1:0] ldm_sym_t;
   localparam ldm_sym_t SYM_ZERO = 2'h0;
   localparam logic [7:0] THR_E1_CODED = 8'h0a;
   localparam logic [7:0] THR_DEFAULT = 8'h0f;
   localparam logic [7:0] THR_SEL1 = 8'h1f;
   localparam logic [7:0] THR_SEL2 = 8'h3f;
   localparam logic [7:0] THR_SEL3 = 8'haf;
   localparam logic [7:0] ZRUN_E1 = 8'h04;
   localparam logic [7:0] ZRUN_T1 = 8'h08;
   localparam logic [7:0] CNT_MAX = 8'hff;

   // Loss threshold from mode, coding and threshold field
   function automatic logic [7:0] ldm_threshold(input logic e1, input logic ami,
                                                 input logic [1:0] sel);
      logic [7:0] t;
      t = THR_DEFAULT;
      case (sel)
         2'h0: t = (e1 && !ami) ? THR_E1_CODED : THR_DEFAULT;
         2'h1: t = THR_SEL1;
         2'h2: t = THR_SEL2;
         default: t = THR_SEL3;
      endcase
      return t;
   endfunction : ldm_threshold
endpackage : ldm_pkg

/* core/ldm_line_decoder.sv */
/*
 Dual-rail line decoder: AMI, HDB3 or B8ZS decoding with violation and
 signature detection. Assumes one symbol per bit_en pulse on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ldm_line_decoder
   import ldm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bit_en,
   input wire logic [1:0] sym_in,
   input wire logic e1_mode,
   input wire logic ami,
   input wire logic violation_rule_select,
   output logic data_bit,
   output logic data_valid,
   output logic lcv_pulse,
   output logic sig_pulse
);
   logic [7:0][1:0] win_reg, win_next;
   logic [7:0] hist_reg, hist_next, mask_reg, mask_next;
   logic last_pol_reg, last_pol_next, last_v_reg, last_v_next;
   logic data_next, valid_next, lcv_next, sig_next;

   // ------------------------------------------------------------
   // Eight-symbol window, substitution masks, violation checks
   // ------------------------------------------------------------
   always_comb
   begin
      logic mark, pol, bpv, hdb, b8, cand1, cand2;
      logic [7:0] z;
      win_next = win_reg;
      hist_next = hist_reg;
      mask_next = mask_reg;
      last_pol_next = last_pol_reg;
      last_v_next = last_v_reg;
      data_next = data_bit;
      valid_next = 1'b0;
      lcv_next = 1'b0;
      sig_next = 1'b0;
      mark = sym_in != SYM_ZERO;
      pol = sym_in[1];
      bpv = mark && (pol == last_pol_reg);
      win_next = {win_reg[6:0], sym_in};
      hist_next = {hist_reg[6:0], bpv};
      for (int i = 0; i < 8; i++)
         z[i] = win_next[i] == SYM_ZERO;
      hdb = bpv && z[1] && z[2];
      b8 = z[7] && z[6] && z[5] && z[2] && !z[4] && !z[3]
           && win_next[4] == win_next[0] && win_next[3] == win_next[1]
           && win_next[4] != win_next[3] && hist_next[4] && hist_next[1];
      cand1 = z[1] && z[2] && z[3];
      cand2 = z[1] && hist_next[3] && z[4] && z[5] && z[6];
      mask_next = {mask_reg[6:0], 1'b0};
      if (!ami && e1_mode && hdb)
         mask_next[3:0] = 4'hf;
      if (!ami && !e1_mode && b8)
         mask_next = 8'hff;
      if (bit_en)
      begin
         if (mark)
            last_pol_next = pol;
         if (bpv)
            last_v_next = pol;
         // Oldest symbol leaves, cleared when part of a substitution
         data_next = (win_reg[7] != SYM_ZERO) && !mask_reg[7];
         valid_next = 1'b1;
         sig_next = e1_mode ? hdb : b8;
         if (ami)
            lcv_next = bpv;
         else if (e1_mode && violation_rule_select)
            lcv_next = bpv && (pol == last_v_reg);
         else if (e1_mode)
            lcv_next = bpv && (!hdb || pol == last_v_reg);
         else
            lcv_next = bpv && !(cand1 || cand2);
      end
      else
      begin
         win_next = win_reg;
         hist_next = hist_reg;
         mask_next = mask_reg;
      end
   end

   // Register decoder state
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         win_reg <= '0;
         hist_reg <= '0;
         mask_reg <= '0;
         last_pol_reg <= 1'b0;
         last_v_reg <= 1'b0;
         data_bit <= 1'b0;
         data_valid <= 1'b0;
         lcv_pulse <= 1'b0;
         sig_pulse <= 1'b0;
      end
      else
      begin
         win_reg <= win_next;
         hist_reg <= hist_next;
         mask_reg <= mask_next;
         last_pol_reg <= last_pol_next;
         last_v_reg <= last_v_next;
         data_bit <= data_next;
         data_valid <= valid_next;
         lcv_pulse <= lcv_next;
         sig_pulse <= sig_next;
      end
   end
endmodule : ldm_line_decoder
`default_nettype wire

/* core/ldm_loss_monitor.sv */
/*
 Consecutive-zero counter: loss-of-signal status and N-zeros event.
 Assumes one symbol per bit_en pulse on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ldm_loss_monitor
   import ldm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bit_en,
   input wire logic mark,
   input wire logic e1_mode,
   input wire logic ami,
   input wire logic [1:0] thr_sel,
   output logic los_status,
   output logic zero_run_pulse
);
   logic [7:0] zcnt_reg, zcnt_next;
   logic los_next, zr_next;

   // ------------------------------------------------------------
   // Zero run counting and loss decision
   // ------------------------------------------------------------
   always_comb
   begin
      logic [7:0] thr;
      thr = ldm_threshold(e1_mode, ami, thr_sel);
      zcnt_next = zcnt_reg;
      los_next = los_status;
      zr_next = 1'b0;
      if (bit_en)
      begin
         if (mark)
         begin
            zcnt_next = '0;
            los_next = 1'b0;
         end
         else
         begin
            if (zcnt_reg != CNT_MAX)
               zcnt_next = zcnt_reg + 8'h01;
            if (zcnt_reg >= thr)
               los_next = 1'b1;
            zr_next = zcnt_next == (e1_mode ? ZRUN_E1 : ZRUN_T1)
                      && zcnt_reg != zcnt_next;
         end
      end
   end

   // Register counter and status
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         zcnt_reg <= '0;
         los_status <= 1'b0;
         zero_run_pulse <= 1'b0;
      end
      else
      begin
         zcnt_reg <= zcnt_next;
         los_status <= los_next;
         zero_run_pulse <= zr_next;
      end
   end
endmodule : ldm_loss_monitor
`default_nettype wire

/* bench/ldm_line_model.sv */
/*
 Line-side model: drives dual-rail symbols and a line clock that runs only
 while a symbol is being sent. Assumes the bench calls its tasks just after
 a rising edge of clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ldm_line_model
(
   input wire logic clk_sys,
   output logic rx_pos,
   output logic rx_neg,
   output logic rx_line_clk
);
   // ------------------------------------------------------------
   // Symbol driver
   // ------------------------------------------------------------
   logic last_pos = 1'b0; // Polarity of the last pulse sent

   // Rails idle low, clock still
   initial
   begin
      rx_pos = 1'b0;
      rx_neg = 1'b0;
      rx_line_clk = 1'b0;
   end

   // One symbol in 16 cycles; a violation repeats the last polarity
   task automatic send_sym(input logic mk, input logic viol);
      logic p;
      p = (mk && !viol) ? !last_pos : last_pos;
      rx_pos = mk & p;
      rx_neg = mk & !p;
      if (mk)
         last_pos = p;
      repeat (4) @(posedge clk_sys);
      #1;
      rx_line_clk = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      rx_line_clk = 1'b0;
      rx_pos = ~rx_pos; // Hold time over: rails no longer valid
      rx_neg = ~rx_neg;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : send_sym

   // String of symbols: 0 space, m alternating mark, v bipolar violation
   task automatic send_str(input string s);
      for (int i = 0; i < s.len(); i++)
         send_sym(s[i] != "0", s[i] == "v");
   endtask : send_str
endmodule : ldm_line_model
`default_nettype wire

/* bench/ldm_top_tb_top.sv */
/*
 Self-checking bench for the quadrant line decoder and loss monitor.
 Assumes ldm_pkg, ldm_top and ldm_line_model are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module ldm_top_tb_top
   import ldm_pkg::*;
;
   logic clk_sys;
   logic resetn;
   logic e1_mode;
   logic rx_pos;
   logic rx_neg;
   logic rx_line_clk;
   logic [ADDR_W-1:0] cpu_addr;
   logic cpu_wr;
   logic cpu_rd;
   logic [DATA_W-1:0] cpu_wdata;
   logic [DATA_W-1:0] cpu_rdata;
   logic rx_data;
   logic rx_data_valid;
   logic loss_of_signal_status;
   logic recovery_algorithm_select;
   logic interrupt_out_n;
   logic got_q[$];
   logic [7:0] rd_val;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;

   ldm_top ldm_top_inst (.clk_sys(clk_sys), .resetn(resetn), .e1_mode(e1_mode),
      .rx_pos(rx_pos), .rx_neg(rx_neg), .rx_line_clk(rx_line_clk), .cpu_addr(cpu_addr),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .rx_data(rx_data), .rx_data_valid(rx_data_valid),
      .loss_of_signal_status(loss_of_signal_status),
      .recovery_algorithm_select(recovery_algorithm_select),
      .interrupt_out_n(interrupt_out_n));

   ldm_line_model ldm_line_model_inst (.clk_sys(clk_sys), .rx_pos(rx_pos), .rx_neg(rx_neg),
      .rx_line_clk(rx_line_clk));

   // ------------------------------------------------------------
   // Clock, timeout and decoded-bit capture
   // ------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Cut a hang short
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         report_and_stop();
      end
      if (rx_data_valid === 1'b1)
         got_q.push_back(rx_data);
   end

   // ------------------------------------------------------------
   // Compare and register tasks
   // ------------------------------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8

   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask : cmp1

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      cpu_wr = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      cpu_rd = 1'b0;
      d = cpu_rdata;
      @(posedge clk_sys);
      #1;
   endtask : reg_rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_rd(a, rd_val);
      cmp8(rd_val, exp);
   endtask : rd_chk

   task automatic end_test(input string name);
      $display("test %s finished, mismatches so far %0d", name, n_fail);
   endtask : end_test

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // ------------------------------------------------------------
   // Scenario tasks
   // ------------------------------------------------------------
   // Zero run up to the threshold, one more zero, then one mark
   task automatic los_chk(input logic e1, input logic [7:0] cfg, input int thr);
      e1_mode = e1;
      reg_wr(ADDR_CFG, cfg);
      ldm_line_model_inst.send_str("mm");
      reg_rd(ADDR_STAT, rd_val);
      repeat (thr) ldm_line_model_inst.send_str("0");
      cmp1(loss_of_signal_status, 1'b0);
      ldm_line_model_inst.send_str("0");
      cmp1(loss_of_signal_status, 1'b1);
      rd_chk(ADDR_STAT, 8'h51);
      ldm_line_model_inst.send_str("m");
      cmp1(loss_of_signal_status, 1'b0);
      reg_rd(ADDR_STAT, rd_val);
      cmp8(rd_val & 8'h7f, 8'h40);
   endtask : los_chk

   // Pattern with masked status check and optional decoded-bit check
   task automatic row(input logic e1, input logic [7:0] cfg, input string p, input string d,
                      input logic [7:0] mask, input logic [7:0] st);
      e1_mode = e1;
      reg_wr(ADDR_CFG, cfg);
      ldm_line_model_inst.send_str("mm");
      reg_rd(ADDR_STAT, rd_val);
      got_q.delete();
      ldm_line_model_inst.send_str(p);
      reg_rd(ADDR_STAT, rd_val);
      cmp8(rd_val & mask, st);
      if (d.len() > 0)
      begin
         ldm_line_model_inst.send_str("00000000");
         for (int i = 0; i < d.len(); i++)
            cmp1(got_q[8 + i], d[i] == "1");
      end
   endtask : row

   // One enable pattern against one event pattern
   task automatic irq_chk(input logic [7:0] en, input string p, input logic exp_n);
      reg_wr(ADDR_IEN, en);
      ldm_line_model_inst.send_str("mm");
      reg_rd(ADDR_STAT, rd_val);
      cmp1(interrupt_out_n, 1'b1);
      ldm_line_model_inst.send_str(p);
      cmp1(interrupt_out_n, exp_n);
      reg_rd(ADDR_STAT, rd_val);
      cmp1(interrupt_out_n, 1'b1);
   endtask : irq_chk

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      resetn = 1'b0;
      e1_mode = 1'b1;
      cpu_addr = 8'h00;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_wdata = 8'h00;
      repeat (10) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      cmp1(interrupt_out_n, 1'b1);
      cmp1(recovery_algorithm_select, 1'b0);
      rd_chk(ADDR_CFG, 8'h00);
      rd_chk(ADDR_IEN, 8'h00);
      rd_chk(ADDR_STAT, 8'h00);
      end_test("reset");
      reg_wr(ADDR_CFG, 8'h86);
      rd_chk(ADDR_CFG, 8'h86);
      cmp1(recovery_algorithm_select, 1'b1);
      reg_wr(ADDR_IEN, 8'hff);
      rd_chk(ADDR_IEN, 8'hf0);
      reg_wr(ADDR_IEN, 8'h00);
      reg_wr(ADDR_STAT, 8'hff);
      rd_chk(ADDR_STAT, 8'h00);
      rd_chk(8'h13, 8'h00);
      reg_wr(ADDR_CFG, 8'h00);
      cmp1(recovery_algorithm_select, 1'b0);
      end_test("registers");
      los_chk(1'b1, 8'h00, 10);
      los_chk(1'b0, 8'h00, 15);
      los_chk(1'b1, 8'h80, 15);
      los_chk(1'b1, 8'h20, 31);
      los_chk(1'b0, 8'h40, 63);
      los_chk(1'b1, 8'he0, 175);
      end_test("loss");
      row(1'b1, 8'h00, "m000vm00vm", "1000000001", 8'h20, 8'h20);
      row(1'b1, 8'h80, "m000vm00vm", "1000110011", 8'ha0, 8'ha0);
      row(1'b0, 8'h00, "m000vm0vmm", "1000000001", 8'ha0, 8'h20);
      row(1'b0, 8'h80, "m000vm0vmm", "1000110111", 8'ha0, 8'ha0);
      end_test("decoding");
      row(1'b1, 8'h00, "mmv", "", 8'h80, 8'h80);
      row(1'b1, 8'h02, "mmv", "", 8'h80, 8'h80);
      row(1'b1, 8'h02, "mv", "", 8'h80, 8'h00);
      row(1'b1, 8'h02, "mmv", "", 8'h80, 8'h80);
      row(1'b0, 8'h02, "mv", "", 8'h80, 8'h80);
      end_test("violation");
      e1_mode = 1'b1;
      reg_wr(ADDR_CFG, 8'h00);
      irq_chk(8'h80, "mmv", 1'b0);
      irq_chk(8'h40, "00000000000m", 1'b0);
      irq_chk(8'h20, "m00v", 1'b0);
      irq_chk(8'h10, "0000m", 1'b0);
      irq_chk(8'h70, "mmv", 1'b1);
      end_test("interrupt");
      report_and_stop();
   end
endmodule : ldm_top_tb_top
`default_nettype wire
